//--- rtl/cpm_pkg.sv
// Purpose: Shared constants and types for the charging port mode decoder.
// Assumes: 250 MHz core clock, 32-bit register port.
// Notes: Pin vector order is {mode_select_1, mode_select_2, mode_select_3, limit_select}.
`default_nettype none
package cpm_pkg;
  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int LOAD_ON_MS = 200;
  localparam int LOAD_OFF_S = 3;
  localparam int DCHG_TIME_US = 1000;
  localparam int LOAD_ON_CYC = LOAD_ON_MS * 1000 * CLK_MHZ;
  localparam int LOAD_OFF_CYC = LOAD_OFF_S * 1000000 * CLK_MHZ;
  localparam int DCHG_CYC = DCHG_TIME_US * CLK_MHZ;
  localparam int CNT_W = 30;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] ADDR_STATE = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam int EV_MODE = 0;
  localparam int EV_LOAD_ON = 1;
  localparam int EV_LOAD_OFF = 2;
  localparam int EV_DCHG_DONE = 3;
  localparam logic [3:0] PINS_RST = 4'h0;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    M_DISCHARGE, M_AUTO, M_STD1, M_SHORTED, M_DIVIDER, M_STD2, M_CDP
  } cpm_mode_e;

  typedef enum logic [1:0] {LIM_LOW, LIM_HIGH, LIM_WAKE} cpm_limit_e;

  typedef struct packed {
    logic ms1;
    logic ms2;
    logic ms3;
    logic lsel;
  } cpm_pins_s;

  // Maps the pin setting onto its charging mode.
  function automatic cpm_mode_e cpm_decode(input cpm_pins_s p);
    cpm_mode_e m;
    m = M_DISCHARGE;
    case ({p.ms1, p.ms2, p.ms3})
      3'h0: m = M_DISCHARGE;
      3'h1, 3'h3: m = M_AUTO;
      3'h2, 3'h6: m = M_STD1;
      3'h4: m = M_SHORTED;
      3'h5: m = M_DIVIDER;
      3'h7: m = p.lsel ? M_CDP : M_STD2;
      default: m = M_DISCHARGE;
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

//--- rtl/cpm_mode_decoder.sv
// Purpose: Decodes the mode-select pins into a charging mode and drives switch,
//   limit, discharge and load status controls, with a small register port.
// Assumes: Load comparator inputs come from analog blocks, already clean.
// Notes: Pin inputs are asynchronous and pass through two flip-flops.
//
// Summary of operation
// R1: Close data switches in CDP and both standard-port modes.
// R2: Data switches close only while enable is high.
// R3: Switches stay closed in CDP during the charging handshake.
// R4: Switches open with all mode pins low or any dedicated mode.
// R5: Power switch current limiting never opens the data switches.
// R6: Switches stay open for the whole output discharge interval.
// R7: Decode mode pins and limit select into the seven charging modes.
// R8: Pick low or high limit per mode and limit select.
// R9: Follow the pins continuously, except while a HID device is detected.
// R10: Status output active only in auto 0011, 0111 and CDP settings.
// R11: In 0011, limit toggles wake/high and load uses wake thresholds.
// R12: CDP and 0111 use normal thresholds; CDP primary detect asserts status.
// R13: No output discharge between the CDP and standard_two codes.
// R14: Forced shorted and divider modes do no automatic scheme switching.
// R15: Status asserts after load above threshold for 200 ms.
// R16: Status deasserts after load below threshold for 3 s.
// R17: Reset returns to the initial discharge state, then follows pins.
// R18: Synchronise the pin inputs before decoding them.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpm_mode_decoder #(
  parameter int LOAD_ON_CYC = cpm_pkg::LOAD_ON_CYC,
  parameter int LOAD_OFF_CYC = cpm_pkg::LOAD_OFF_CYC,
  parameter int DCHG_CYC = cpm_pkg::DCHG_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mode_select_1,
  input wire logic mode_select_2,
  input wire logic mode_select_3,
  input wire logic limit_select,
  input wire logic enable,
  input wire logic load_over,
  input wire logic load_under,
  input wire logic wake_over,
  input wire logic wake_under,
  input wire logic primary_detect,
  input wire logic hid_detected,
  output logic data_switch_close,
  output cpm_pkg::cpm_limit_e limit_choice,
  output logic auto_scheme_en,
  output logic discharge_active,
  output logic status_n,
  output logic irq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // ****************************************************************
  // Parameter checks.
  // ****************************************************************
  if (LOAD_ON_CYC < 1 || LOAD_OFF_CYC < 1 || DCHG_CYC < 1) begin : g_chk_min
    $error("cpm_mode_decoder: counts must be at least one");
  end
  if (LOAD_ON_CYC >= 2**cpm_pkg::CNT_W || LOAD_OFF_CYC >= 2**cpm_pkg::CNT_W ||
      DCHG_CYC >= 2**cpm_pkg::CNT_W) begin : g_chk_max
    $error("cpm_mode_decoder: counts exceed counter width");
  end

  localparam logic [cpm_pkg::CNT_W-1:0] ON_LAST = cpm_pkg::CNT_W'(LOAD_ON_CYC - 1);
  localparam logic [cpm_pkg::CNT_W-1:0] OFF_LAST = cpm_pkg::CNT_W'(LOAD_OFF_CYC - 1);
  localparam logic [cpm_pkg::CNT_W-1:0] DCHG_LOAD = cpm_pkg::CNT_W'(DCHG_CYC);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  cpm_pkg::cpm_pins_s pins_raw;
  cpm_pkg::cpm_pins_s pins_meta;
  cpm_pkg::cpm_pins_s pins_sync;
  cpm_pkg::cpm_pins_s cur_pins;
  logic en_meta;
  logic en_sync;

  assign pins_raw = '{mode_select_1, mode_select_2, mode_select_3, limit_select};

  // Two flip-flops per pin; only the second stage is used downstream.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pins_meta <= cpm_pkg::PINS_RST;
      pins_sync <= cpm_pkg::PINS_RST;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      pins_meta <= pins_raw; // [R18]
      pins_sync <= pins_meta; // [R18]
      en_meta <= enable;
      en_sync <= en_meta;
    end
  end

  // ****************************************************************
  // Mode tracking and discharge.
  // ****************************************************************
  cpm_pkg::cpm_pins_s next_pins;
  cpm_pkg::cpm_mode_e cur_mode;
  cpm_pkg::cpm_mode_e next_mode;
  logic mode_chg;
  logic pair_swap;
  logic [cpm_pkg::CNT_W-1:0] dchg_cnt;
  logic dchg_done;

  // A detected HID device freezes the applied setting.
  assign next_pins = hid_detected ? cur_pins : pins_sync; // [R9]
  assign cur_mode = cpm_pkg::cpm_decode(cur_pins); // [R7]
  assign next_mode = cpm_pkg::cpm_decode(next_pins); // [R7]
  assign mode_chg = next_mode != cur_mode;
  // Swapping between CDP and standard_two keeps the port powered.
  assign pair_swap = (cur_mode == cpm_pkg::M_CDP && next_mode == cpm_pkg::M_STD2) ||
                     (cur_mode == cpm_pkg::M_STD2 && next_mode == cpm_pkg::M_CDP); // [R13]
  assign dchg_done = dchg_cnt == cpm_pkg::CNT_W'(1);

  // Reset lands in the all-low setting, which is the discharge state.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cur_pins <= cpm_pkg::PINS_RST; // [R17]
    end else begin
      cur_pins <= next_pins; // [R9]
    end
  end

  // Timed discharge on every mode change except the CDP/standard_two swap and changes into or out of discharge.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dchg_cnt <= '0;
    end else if (mode_chg && !pair_swap && next_mode != cpm_pkg::M_DISCHARGE &&
                 cur_mode != cpm_pkg::M_DISCHARGE) begin
      dchg_cnt <= DCHG_LOAD; // [R13]
    end else if (dchg_cnt != '0) begin
      dchg_cnt <= dchg_cnt - cpm_pkg::CNT_W'(1);
    end
  end

  // ****************************************************************
  // Load detection and status.
  // ****************************************************************
  logic ld_mode;
  logic wake_set;
  logic above;
  logic below;
  logic [cpm_pkg::CNT_W-1:0] ld_cnt;
  logic [cpm_pkg::CNT_W-1:0] next_ld_cnt;
  logic next_status_n;

  // Load detect runs in auto with limit select high, and in CDP.
  assign ld_mode = cur_mode == cpm_pkg::M_CDP ||
                   (cur_mode == cpm_pkg::M_AUTO && cur_pins.lsel); // [R10]
  assign wake_set = cur_pins == cpm_pkg::cpm_pins_s'(4'h3); // [R11]
  assign above = wake_set ? wake_over : load_over; // [R11] [R12]
  assign below = wake_set ? wake_under : load_under; // [R11] [R12]

  // Qualify the comparator levels for the set and clear times.
  always_comb begin
    next_status_n = status_n;
    next_ld_cnt = '0;
    if (!ld_mode) begin
      next_status_n = 1'b1; // [R10]
    end else if (status_n) begin
      if (cur_mode == cpm_pkg::M_CDP && primary_detect) begin
        next_status_n = 1'b0; // [R12]
      end else if (above) begin
        if (ld_cnt == ON_LAST) begin
          next_status_n = 1'b0; // [R15]
        end else begin
          next_ld_cnt = ld_cnt + cpm_pkg::CNT_W'(1); // [R15]
        end
      end
    end else if (below) begin
      if (ld_cnt == OFF_LAST) begin
        next_status_n = 1'b1; // [R16]
      end else begin
        next_ld_cnt = ld_cnt + cpm_pkg::CNT_W'(1); // [R16]
      end
    end
  end

  // Status and its qualification counter.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_n <= 1'b1;
      ld_cnt <= '0;
    end else begin
      status_n <= next_status_n;
      ld_cnt <= next_ld_cnt;
    end
  end

  // ****************************************************************
  // Switch and limit outputs.
  // ****************************************************************
  logic next_switch;
  cpm_pkg::cpm_limit_e next_limit;

  // Current limiting of the power switch plays no part here.
  assign next_switch = en_sync && dchg_cnt == '0 &&
    (cur_mode == cpm_pkg::M_CDP || cur_mode == cpm_pkg::M_STD1 ||
     cur_mode == cpm_pkg::M_STD2); // [R1] [R2] [R3] [R4] [R5] [R6]

  // Limit source per mode.
  always_comb begin
    case (cur_mode)
      cpm_pkg::M_STD1, cpm_pkg::M_SHORTED, cpm_pkg::M_DIVIDER: begin
        next_limit = cur_pins.lsel ? cpm_pkg::LIM_HIGH : cpm_pkg::LIM_LOW; // [R8]
      end
      cpm_pkg::M_STD2: begin
        next_limit = cpm_pkg::LIM_LOW; // [R8]
      end
      cpm_pkg::M_AUTO, cpm_pkg::M_CDP: begin
        // Wake limit while no load is seen in the power-wake setting.
        next_limit = (wake_set && status_n) ? cpm_pkg::LIM_WAKE : cpm_pkg::LIM_HIGH; // [R11]
      end
      default: begin
        next_limit = cpm_pkg::LIM_LOW;
      end
    endcase
  end

  // Registered control outputs.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      data_switch_close <= 1'b0;
      limit_choice <= cpm_pkg::LIM_LOW;
      auto_scheme_en <= 1'b0;
      discharge_active <= 1'b1; // [R17]
    end else begin
      data_switch_close <= next_switch;
      limit_choice <= next_limit;
      auto_scheme_en <= cur_mode == cpm_pkg::M_AUTO; // [R14]
      discharge_active <= cur_mode == cpm_pkg::M_DISCHARGE || dchg_cnt != '0; // [R6]
    end
  end

  // ****************************************************************
  // Register port and interrupt.
  // ****************************************************************
  logic [cpm_pkg::IRQ_W-1:0] irq_stat;
  logic [cpm_pkg::IRQ_W-1:0] irq_mask;
  logic [cpm_pkg::IRQ_W-1:0] events;
  logic [cpm_pkg::IRQ_W-1:0] w1c;

  assign events[cpm_pkg::EV_MODE] = mode_chg;
  assign events[cpm_pkg::EV_LOAD_ON] = status_n && !next_status_n;
  assign events[cpm_pkg::EV_LOAD_OFF] = !status_n && next_status_n;
  assign events[cpm_pkg::EV_DCHG_DONE] = dchg_done;
  assign w1c = (reg_wr && reg_addr == cpm_pkg::ADDR_IRQ_STAT) ?
               reg_wdata[cpm_pkg::IRQ_W-1:0] : '0;
  assign irq = |(irq_stat & irq_mask);

  // Sticky status: a new event wins over a same-cycle clear.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | events;
    end
  end

  // Mask register.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_mask <= cpm_pkg::IRQ_MASK_RST;
    end else if (reg_wr && reg_addr == cpm_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata[cpm_pkg::IRQ_W-1:0];
    end
  end

  // Read data, valid only in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (!resetn || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        cpm_pkg::ADDR_STATE: begin
          reg_rdata <= {19'h0_0000, cur_pins, 1'b0, cur_mode, status_n,
                        discharge_active, data_switch_close, limit_choice};
        end
        cpm_pkg::ADDR_IRQ_STAT: begin
          reg_rdata <= {28'h000_0000, irq_stat};
        end
        cpm_pkg::ADDR_IRQ_MASK: begin
          reg_rdata <= {28'h000_0000, irq_mask};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_enable_gates_switch: assert property (!enable [*4] |=> !data_switch_close) // [R2]
    else $error("data switch closed with enable low");
  a_cdp_closes_switch: assert property ( // [R1]
    cur_mode == cpm_pkg::M_CDP && en_sync && dchg_cnt == '0 |=> data_switch_close)
    else $error("data switch open in CDP");
  a_dcp_opens_switch: assert property ( // [R4]
    cur_mode inside {cpm_pkg::M_AUTO, cpm_pkg::M_SHORTED, cpm_pkg::M_DIVIDER,
      cpm_pkg::M_DISCHARGE} |=> !data_switch_close)
    else $error("data switch closed in dedicated or discharge mode");
  a_dchg_opens_switch: assert property (discharge_active |-> !data_switch_close) // [R6]
    else $error("data switch closed during discharge");
  a_decode_follows: assert property ( // [R7]
    ($stable(pins_raw) && !hid_detected) [*4] |-> cur_mode == cpm_pkg::cpm_decode(pins_raw))
    else $error("applied mode differs from pins");
  a_hid_freezes: assert property (hid_detected |=> $stable(cur_pins)) // [R9]
    else $error("setting changed while HID detected");
  a_std2_low_limit: assert property ( // [R8]
    cur_mode == cpm_pkg::M_STD2 |=> limit_choice == cpm_pkg::LIM_LOW)
    else $error("standard_two not on low limit");
  a_swap_no_dchg: assert property ( // [R13]
    pair_swap && dchg_cnt == '0 |=> dchg_cnt == '0)
    else $error("discharge on CDP/standard_two swap");
  a_status_mode: assert property (!status_n |-> $past(ld_mode)) // [R10]
    else $error("status active outside load-detect modes");
  a_status_on_time: assert property ( // [R15]
    $fell(status_n) && !$past(primary_detect) |-> $past(ld_cnt) == ON_LAST)
    else $error("status set before qualification time");
  a_status_off_time: assert property ( // [R16]
    $rose(status_n) && $past(ld_mode) |-> $past(ld_cnt) == OFF_LAST)
    else $error("status cleared before qualification time");
  a_reset_discharge: assert property ($rose(resetn) |-> discharge_active) // [R17]
    else $error("not discharging after reset");

  c_cdp_closed: cover property (cur_mode == cpm_pkg::M_CDP ##1 data_switch_close);
  c_status_on: cover property ($fell(status_n));
  c_dchg_done: cover property (dchg_done ##1 !discharge_active);
  c_swap: cover property (pair_swap);
endmodule
`default_nettype wire

//--- tb/cpm_pin_host.sv
// Purpose: Power controller model that drives the mode and enable pins.
// Assumes: Pins change only right after a rising clock edge.
// Notes: Holds each requested setting as a steady level.
`timescale 1ns/1ps
`default_nettype none
module cpm_pin_host (
  input wire logic core_clk,
  input wire cpm_pkg::cpm_pins_s want,
  input wire logic want_en,
  output logic mode_select_1,
  output logic mode_select_2,
  output logic mode_select_3,
  output logic limit_select,
  output logic enable
);
  // Registers the requested setting onto the pins, as a controller GPIO would.
  always_ff @(posedge core_clk) begin
    mode_select_1 <= want.ms1;
    mode_select_2 <= want.ms2;
    mode_select_3 <= want.ms3;
    limit_select <= want.lsel;
    enable <= want_en;
  end
endmodule
`default_nettype wire

//--- tb/test_charging_port_mode_decoder.sv
// Purpose: Self-checking bench for the charging port mode decoder.
// Assumes: Shortened counts 8/12/5 for load on, load off and discharge.
// Notes: Each scenario is one task that drives and judges.
`timescale 1ns/1ps
`default_nettype none
module test_charging_port_mode_decoder;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  cpm_pkg::cpm_pins_s want = 4'h0;
  logic want_en = 1'b1;
  logic ms1, ms2, ms3, lsel, en;
  logic load_over = 1'b0, load_under = 1'b0, primary_detect = 1'b0, hid_detected = 1'b0;
  logic wake_over = 1'b0, wake_under = 1'b0;
  logic data_switch_close, auto_scheme_en, discharge_active, status_n, irq;
  cpm_pkg::cpm_limit_e limit_choice;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  int mismatches = 0, n_tests = 0, n;
  // Makes the 250 MHz clock.
  always #2 core_clk = ~core_clk;
  cpm_pin_host host (.core_clk(core_clk), .want(want), .want_en(want_en), .mode_select_1(ms1),
    .mode_select_2(ms2), .mode_select_3(ms3), .limit_select(lsel), .enable(en));
  cpm_mode_decoder #(.LOAD_ON_CYC(8), .LOAD_OFF_CYC(12), .DCHG_CYC(5)) dut (
    .core_clk(core_clk), .resetn(resetn), .mode_select_1(ms1), .mode_select_2(ms2),
    .mode_select_3(ms3), .limit_select(lsel), .enable(en), .load_over(load_over),
    .load_under(load_under), .wake_over(wake_over), .wake_under(wake_under),
    .primary_detect(primary_detect), .hid_detected(hid_detected),
    .data_switch_close(data_switch_close), .limit_choice(limit_choice),
    .auto_scheme_en(auto_scheme_en), .discharge_active(discharge_active), .status_n(status_n),
    .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic go(input logic [3:0] p, input int w);
    @(posedge core_clk);
    want <= p;
    repeat (w) @(posedge core_clk);
  endtask
  task automatic t_reset;
    chk(discharge_active, 1, "reset discharge");
    chk({data_switch_close, status_n, irq}, 3'b010, "reset outputs");
    rd(8'h08);
    chk(d, 0, "mask reset");
    rd(8'h0c);
    chk(d, 0, "unmapped read");
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00);
    chk(d[7:5], 0, "state after write");
  endtask
  // Walks all sixteen settings and checks the decoded mode, limit and switch.
  task automatic t_decode;
    logic [2:0] m;
    logic s;
    logic [1:0] l;
    for (int i = 0; i < 16; i++) begin
      case (i[3:1])
        3'd0: {m, s, l} = {3'd0, 1'b0, 2'd0};
        3'd1, 3'd3: {m, s, l} = {3'd1, 1'b0, (i == 3) ? 2'd2 : 2'd1};
        3'd2, 3'd6: {m, s, l} = {3'd2, 1'b1, 1'b0, i[0]};
        3'd4: {m, s, l} = {3'd3, 1'b0, 1'b0, i[0]};
        3'd5: {m, s, l} = {3'd4, 1'b0, 1'b0, i[0]};
        default: {m, s, l} = i[0] ? {3'd6, 1'b1, 2'd1} : {3'd5, 1'b1, 2'd0};
      endcase
      go(i[3:0], 30);
      rd(8'h00);
      chk(d[7:5], m, "mode");
      if (m != 0) chk(limit_choice, l, "limit");
      chk(data_switch_close, s, "switch");
      chk(auto_scheme_en, m == 1, "auto scheme");
      chk(discharge_active, m == 0, "discharge");
    end
  endtask
  task automatic t_enable;
    @(posedge core_clk);
    want_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(data_switch_close, 1, "synchroniser delay");
    repeat (10) @(posedge core_clk);
    #1 chk(data_switch_close, 0, "enable low");
    @(posedge core_clk);
    want_en <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 chk(data_switch_close, 1, "enable high");
  endtask
  // From CDP to standard_two and back, with a handshake at the start while still in CDP.
  task automatic t_cdp_std2;
    @(posedge core_clk);
    want <= 4'he;
    primary_detect <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk);
      primary_detect <= 1'b0;
      if (i == 15) want <= 4'hf;
      #1 chk({discharge_active, data_switch_close}, 2'b01, "no discharge");
    end
  endtask
  task automatic t_discharge(input logic [3:0] p);
    wr(8'h04, 32'h0000_000f);
    n = 0;
    @(posedge core_clk);
    want <= p;
    repeat (30) begin
      @(posedge core_clk);
      #1 if (discharge_active === 1'b1) n++;
      if (discharge_active === 1'b1) chk(data_switch_close, 0, "switch in discharge");
    end
    chk(n, 5, "discharge length");
    rd(8'h04);
    chk(d[3:0], 4'h9, "mode and discharge events");
  endtask
  task automatic t_load;
    go(4'hf, 30);
    wr(8'h04, 32'h0000_000f);
    wr(8'h08, 32'h0000_0002);
    @(posedge core_clk);
    load_over <= 1'b1;
    n = 0;
    while (status_n !== 1'b0 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n, 8, "load on time");
    chk(irq, 1, "irq raised");
    chk(data_switch_close, 1, "switch under load");
    rd(8'h04);
    chk(d[1], 1, "status event");
    wr(8'h04, 32'h0000_0002);
    #1 chk(irq, 0, "irq cleared");
    @(posedge core_clk);
    load_over <= 1'b0;
    load_under <= 1'b1;
    n = 0;
    while (status_n !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n, 12, "load off time");
    @(posedge core_clk);
    load_under <= 1'b0;
    rd(8'h04);
    chk(d[2], 1, "release event");
  endtask
  task automatic t_nostatus;
    go(4'h5, 30);
    load_over <= 1'b1;
    repeat (30) @(posedge core_clk);
    load_over <= 1'b0;
    #1 chk(status_n, 1, "no status in standard_one");
  endtask
  task automatic t_primary;
    go(4'hf, 30);
    primary_detect <= 1'b1;
    @(posedge core_clk);
    primary_detect <= 1'b0;
    #1 chk(status_n, 0, "primary detect");
  endtask
  task automatic t_hid;
    @(posedge core_clk);
    hid_detected <= 1'b1;
    go(4'h4, 30);
    rd(8'h00);
    chk(d[7:5], 6, "frozen by hid");
    @(posedge core_clk);
    hid_detected <= 1'b0;
    go(4'h4, 30);
    rd(8'h00);
    chk(d[7:5], 2, "follows after hid");
  endtask
  // Power-wake setting: only the wake comparators count, and the limit follows the load.
  task automatic t_wake;
    go(4'h3, 30);
    load_over <= 1'b1;
    repeat (20) @(posedge core_clk);
    load_over <= 1'b0;
    wake_over <= 1'b1;
    #1 chk({status_n, limit_choice}, 3'b110, "normal comparator ignored");
    n = 0;
    while (status_n !== 1'b0 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n, 8, "wake load on time");
    @(posedge core_clk);
    wake_over <= 1'b0;
    wake_under <= 1'b1;
    #1 chk(limit_choice, 1, "high limit under load");
    n = 0;
    while (status_n !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n, 12, "wake load off time");
    @(posedge core_clk);
    wake_under <= 1'b0;
  endtask
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    results();
  end
  // Runs the scenarios in order.
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 t_reset();
    t_decode();
    t_enable();
    t_cdp_std2();
    t_discharge(4'h5);
    t_load();
    t_nostatus();
    t_primary();
    t_hid();
    t_wake();
    results();
  end
endmodule
`default_nettype wire
